//--- port_a_gpio.sv
// How it works
// [R1] A direction bit at one turns the pin driver off; the direction register resets to all ones.
// [R2] A direction bit at zero turns the pin driver on and drives the latch value.
// [R3] A pin with its analog-select bit set reads as zero on port reads; the timer and slave-select inputs still follow its pad.
// [R4] The analog-select bits never change the digital output drive.
// [R5] Analog-select bits seven and six are unimplemented and read as zero.
// [R6] Analog-select one makes the low pin analog with its port read masked to zero, zero gives it to digital use; reset is ones.
// [R7] Software must set the direction bit to input on a pin it selects as analog.
// [R8] A port write merges with pin levels that read zero on analog pins, so their latch bits can change.
// [R9] Each pin is shared between general use and peripheral functions chosen by the peripherals.
// [R10] The timer clock input always follows pin four's pad, whatever its direction bit.
// [R11] The serial slave-select input comes from pin five or pin zero by the pin-selection bit.
// [R12] Pin three also feeds the converter's voltage reference input.
// [R13] Reading the port gives pin levels, writing it loads the output latch.
// [R14] Every port write reads the pins, merges the strobed bytes, and stores the result in the latch.
// [R15] Direction bits keep steering the drivers while pins serve as analog inputs.
// [R16] Register writes act on the next edge and pin reads pass a synchroniser.
// [R17] An enabled peripheral output overrides the latch and direction for that pin.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module port_a_gpio (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // AXI4-Lite write address and data.
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pads.
   input  wire logic [7:0]  pad_in,
   output logic [7:0]       pad_out,
   output logic [7:0]       pad_oe,
   // Peripheral overrides.
   input  wire logic [7:0]  periph_own,
   input  wire logic [7:0]  periph_out,
   input  wire logic [7:0]  periph_oe,
   // Peripheral inputs.
   output logic             timer_zero_clock_in,
   output logic             slave_select_in,
   output logic             adc_vref_in,
   output logic [5:0]       analog_enable
);
   // ==========================================================================
   // State machine for the write channel.
   typedef enum logic [2:0] {
      w_idle = 3'b001,
      w_exec = 3'b010,
      w_resp = 3'b100
   } write_state_type;

   write_state_type write_state;
   logic [7:0]      port_a_pin_latch;
   logic [7:0]      port_a_direction;
   logic [5:0]      analog_select_bits;
   logic            slave_select_pin_choice;
   logic [7:0]      pin_level;
   logic [7:0]      digital_read;
   logic [3:0]      aw_addr;
   logic [31:0]     w_data;
   logic            w_byte0;
   logic            have_aw;
   logic            have_w;
   logic [7:0]      next_latch;
   logic [7:0]      next_out;
   logic [7:0]      next_oe;
   logic [31:0]     next_rdata;
   logic            read_hit;

   // ==========================================================================
   // Pad synchronisers.
   genvar i;
   generate
      for (i = 0; i < gpio_port_pkg::port_width; i++) begin : g_sync
         pin_sync u_sync (
            .clock (clock),
            .rst   (rst),
            .pad_in(pad_in[i]),
            .level (pin_level[i])
         ); // see [R16]
      end
   endgenerate

   always_comb begin
      digital_read = pin_level & ~{2'h0, analog_select_bits}; // see [R3] see [R13]
   end

   // ==========================================================================
   // Write channel.
   always_ff @(posedge clock) begin
      if (rst) begin
         have_aw       <= 1'b0;
         have_w        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h00000000;
         w_byte0       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= gpio_port_pkg::resp_okay;
         write_state   <= w_idle;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         case (write_state)
            w_idle: begin
               if (s_axi_awvalid && !have_aw && !s_axi_awready) begin
                  s_axi_awready <= 1'b1;
               end
               if (s_axi_wvalid && !have_w && !s_axi_wready) begin
                  s_axi_wready <= 1'b1;
               end
               if (s_axi_awvalid && s_axi_awready) begin
                  have_aw <= 1'b1;
                  aw_addr <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  have_w  <= 1'b1;
                  w_data  <= s_axi_wdata;
                  w_byte0 <= s_axi_wstrb[0];
               end
               if (have_aw && have_w) begin
                  write_state <= w_exec;
               end
            end
            w_exec: begin
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= (aw_addr[1:0] == 2'h0) ? gpio_port_pkg::resp_okay : gpio_port_pkg::resp_slverr;
               write_state  <= w_resp;
            end
            w_resp: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  have_aw      <= 1'b0;
                  have_w       <= 1'b0;
                  write_state  <= w_idle;
               end
            end
            default: begin
               write_state <= w_idle;
            end
         endcase
      end
   end

   // ==========================================================================
   // Register file.
   always_comb begin
      next_latch = digital_read; // see [R8] see [R14]
      if (w_byte0) begin
         next_latch = w_data[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         port_a_pin_latch        <= gpio_port_pkg::latch_reset;
         port_a_direction        <= gpio_port_pkg::direction_reset; // see [R1]
         analog_select_bits      <= gpio_port_pkg::analog_select_reset; // see [R6]
         slave_select_pin_choice <= 1'b0;
      end else if (write_state == w_exec) begin
         case (aw_addr)
            gpio_port_pkg::latch_offset: begin
               port_a_pin_latch <= next_latch; // see [R14] see [R16]
            end
            gpio_port_pkg::direction_offset: begin
               if (w_byte0) begin
                  port_a_direction <= w_data[7:0];
               end
            end
            gpio_port_pkg::analog_select_offset: begin
               if (w_byte0) begin
                  analog_select_bits <= w_data[5:0]; // see [R5] see [R6]
               end
            end
            gpio_port_pkg::pin_choice_offset: begin
               if (w_byte0) begin
                  slave_select_pin_choice <= w_data[gpio_port_pkg::slave_select_field];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // Read channel.
   always_comb begin
      read_hit   = 1'b1;
      next_rdata = 32'h00000000;
      case (s_axi_araddr)
         gpio_port_pkg::latch_offset:         next_rdata = {24'h000000, digital_read}; // see [R13]
         gpio_port_pkg::direction_offset:     next_rdata = {24'h000000, port_a_direction};
         gpio_port_pkg::analog_select_offset: next_rdata = {26'h0000000, analog_select_bits}; // see [R5]
         gpio_port_pkg::pin_choice_offset:    next_rdata = {31'h00000000, slave_select_pin_choice};
         default:                             read_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= gpio_port_pkg::resp_okay;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= read_hit ? gpio_port_pkg::resp_okay : gpio_port_pkg::resp_slverr;
         end
      end
   end

   // ==========================================================================
   // Pad drive and peripheral multiplexing.
   always_comb begin
      next_out = port_a_pin_latch; // see [R2] see [R4]
      next_oe  = ~port_a_direction; // see [R1] see [R2] see [R15]
      for (int k = 0; k < gpio_port_pkg::port_width; k++) begin
         if (periph_own[k]) begin
            next_out[k] = periph_out[k]; // see [R17] see [R9]
            next_oe[k]  = periph_oe[k];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pad_out             <= 8'h00;
         pad_oe              <= 8'h00;
         timer_zero_clock_in <= 1'b0;
         slave_select_in     <= 1'b1;
         adc_vref_in         <= 1'b0;
         analog_enable       <= 6'h3F;
      end else begin
         pad_out             <= next_out;
         pad_oe              <= next_oe;
         timer_zero_clock_in <= pin_level[gpio_port_pkg::timer_pin]; // see [R10]
         slave_select_in     <= slave_select_pin_choice ? pin_level[0] : pin_level[5]; // see [R11]
         adc_vref_in         <= pin_level[gpio_port_pkg::vref_pin]; // see [R12]
         analog_enable       <= analog_select_bits; // see [R6] see [R9]
      end
   end

   // ==========================================================================
   // Checks.
   a_analog_reads_zero: assert property (@(posedge clock) disable iff (rst) // see [R3]
      analog_select_bits[0] |-> digital_read[0] == 1'b0) else $error("Analog pin read not zero.");
   a_direction_drive: assert property (@(posedge clock) disable iff (rst) // see [R1]
      !periph_own[2] ##1 !periph_own[2] |-> pad_oe[2] == !$past(port_a_direction[2])) else $error("Drive enable wrong.");
   a_latch_on_pad: assert property (@(posedge clock) disable iff (rst) // see [R2]
      !periph_own[1] |=> pad_out[1] == $past(port_a_pin_latch[1])) else $error("Pad not latch.");
   a_analog_no_drive: assert property (@(posedge clock) disable iff (rst) // see [R4]
      analog_select_bits[3] && !port_a_direction[3] && !periph_own[3]
      |=> pad_oe[3] && pad_out[3] == $past(port_a_pin_latch[3])) else $error("Analog changed drive.");
   a_upper_zero: assert property (@(posedge clock) disable iff (rst) // see [R5]
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("Upper bits set.");
   a_timer_follows: assert property (@(posedge clock) disable iff (rst) // see [R10]
      !rst |=> timer_zero_clock_in == $past(pin_level[4])) else $error("Timer input wrong.");
   a_slave_select: assert property (@(posedge clock) disable iff (rst) // see [R11]
      !rst |=> slave_select_in == ($past(slave_select_pin_choice) ? $past(pin_level[0]) : $past(pin_level[5])))
      else $error("Slave select wrong.");
   a_write_response: assert property (@(posedge clock) disable iff (rst) // see [R16]
      write_state == w_exec |=> s_axi_bvalid) else $error("No write response.");
   a_rmw_merge: assert property (@(posedge clock) disable iff (rst) // see [R8]
      write_state == w_exec && aw_addr == gpio_port_pkg::latch_offset && !w_byte0
      |=> port_a_pin_latch == $past(digital_read)) else $error("Merge wrong.");
   c_write: cover property (@(posedge clock) s_axi_bvalid && s_axi_bready);
   c_read: cover property (@(posedge clock) s_axi_rvalid && s_axi_rready);
   c_override: cover property (@(posedge clock) periph_own != 8'h00);
endmodule : port_a_gpio

//--- gpio_port_pkg.sv
package gpio_port_pkg;
   // ==========================================================================
   // Register map.
   localparam logic [3:0] latch_offset         = 4'h0;
   localparam logic [3:0] direction_offset     = 4'h4;
   localparam logic [3:0] analog_select_offset = 4'h8;
   localparam logic [3:0] pin_choice_offset    = 4'hC;
   // ==========================================================================
   // Reset values and field layouts.
   localparam logic [7:0] direction_reset     = 8'hFF;
   localparam logic [5:0] analog_select_reset = 6'h3F;
   localparam logic [7:0] latch_reset         = 8'h00;
   localparam int         analog_width        = 6;
   localparam int         port_width          = 8;
   localparam int         slave_select_field  = 0;
   localparam int         timer_pin           = 4;
   localparam int         vref_pin            = 3;
   localparam logic [1:0] resp_okay           = 2'h0;
   localparam logic [1:0] resp_slverr         = 2'h2;
endpackage : gpio_port_pkg

//--- pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Pad level in and synchronised level out.
   input  wire logic pad_in,
   output logic      level
);
   // ==========================================================================
   // Two flip-flop synchroniser.
   logic stage_one;
   always_ff @(posedge clock) begin
      if (rst) begin
         stage_one <= 1'b0;
         level     <= 1'b0;
      end else begin
         stage_one <= pad_in;
         level     <= stage_one;
      end
   end
endmodule : pin_sync

//--- pin_model.sv
`timescale 1ns/10ps
// ==========
// Pad model: a pin follows the design when it drives, else the outside level or a toggling float.
module pin_model (
   // Clock.
   input  wire logic       clock,
   // Design side.
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   // Outside world.
   input  wire logic [7:0] ext_level,
   input  wire logic [7:0] ext_drive,
   output logic [7:0]      pad_in
);
   logic [7:0] float_level = 8'h55;
   always @(posedge clock) begin
      float_level <= ~float_level;
   end
   always_comb begin
      pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level) | (~pad_oe & ~ext_drive & float_level);
   end
endmodule : pin_model

//--- port_a_gpio_tb.sv
`timescale 1ns/10ps
module port_a_gpio_tb;
   localparam logic [3:0] lat_a = gpio_port_pkg::latch_offset;
   localparam logic [3:0] dir_a = gpio_port_pkg::direction_offset;
   localparam logic [3:0] ans_a = gpio_port_pkg::analog_select_offset;
   localparam logic [3:0] sel_a = gpio_port_pkg::pin_choice_offset;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, timer_in, ss_in, vref_in;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  pad_in, pad_out, pad_oe, got, ext_level = 8'h00, ext_drive = 8'hFF;
   logic [7:0]  periph_own = 8'h00, periph_out = 8'h00, periph_oe = 8'h00;
   logic [5:0]  an_en;
   int          err_count = 0;
   int          check_count = 0;
   always #20 clock = ~clock;
   port_a_gpio u_port_a_gpio (
      .clock(clock), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .periph_own(periph_own), .periph_out(periph_out), .periph_oe(periph_oe),
      .timer_zero_clock_in(timer_in), .slave_select_in(ss_in), .adc_vref_in(vref_in), .analog_enable(an_en)
   );
   pin_model u_pin_model (
      .clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
      .ext_level(ext_level), .ext_drive(ext_drive), .pad_in(pad_in)
   );
   // ==========
   // Reporting.
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_val
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected response at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_resp
   task automatic limit(input int n);
      if (n >= 40) begin
         err_count++;
         stop_test();
      end
   endtask : limit
   // ==========
   // Bus cycles.
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      int   n;
      logic aw_open;
      logic w_open;
      n = 0;
      aw_open = 1'b1;
      w_open = 1'b1;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while ((aw_open || w_open) && n < 40) begin
         @(posedge clock);
         n++;
         if (aw_open && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_open = 1'b0;
         end
         if (w_open && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_open = 1'b0;
         end
      end
      do begin
         @(posedge clock);
         n++;
      end while (bvalid !== 1'b1 && n < 40);
      resp = bresp;
      bready <= 1'b0;
      limit(n);
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (arready !== 1'b1 && n < 40);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 40) begin
         @(posedge clock);
         n++;
      end
      got = rdata[7:0];
      resp = rresp;
      rready <= 1'b0;
      limit(n);
      @(posedge clock);
   endtask : rd
   // ==========
   // Scenarios.
   task automatic sc_output();
      wr(ans_a, 8'h00, 4'h1);
      wr(lat_a, 8'hA5, 4'h1);
      wr(dir_a, 8'h00, 4'h1);
      chk_resp(resp, gpio_port_pkg::resp_okay);
      repeat (4) @(posedge clock);
      chk_val(pad_oe, 8'hFF);
      chk_val(pad_out, 8'hA5);
      rd(lat_a);
      chk_val(got, 8'hA5);
      chk_resp(resp, gpio_port_pkg::resp_okay);
   endtask : sc_output
   task automatic sc_analog();
      wr(dir_a, 8'hFF, 4'h1);
      ext_level <= 8'hFF;
      wr(ans_a, 8'hFF, 4'h1);
      repeat (4) @(posedge clock);
      rd(ans_a);
      chk_val(got, 8'h3F);
      chk_val({2'b00, an_en}, 8'h3F);
      wr(ans_a, 8'h0F, 4'h1);
      ext_drive <= 8'hF0;
      repeat (4) @(posedge clock);
      rd(lat_a);
      chk_val(got, 8'hF0);
      ext_drive <= 8'hFF;
   endtask : sc_analog
   task automatic sc_rmw();
      wr(dir_a, 8'h00, 4'h1);
      wr(lat_a, 8'hA5, 4'h1);
      wr(ans_a, 8'h3F, 4'h1);
      repeat (4) @(posedge clock);
      chk_val(pad_out, 8'hA5);
      chk_val(pad_oe, 8'hFF);
      wr(lat_a, 8'h00, 4'h0);
      repeat (4) @(posedge clock);
      chk_val(pad_out, 8'h80);
   endtask : sc_rmw
   task automatic sc_periph();
      wr(ans_a, 8'h00, 4'h1);
      wr(dir_a, 8'hFF, 4'h1);
      for (int c = 0; c < 2; c++) begin
         wr(sel_a, 8'(c), 4'h1);
         ext_level <= (c == 1) ? 8'h19 : 8'h38;
         repeat (4) @(posedge clock);
         chk_val({7'h00, ss_in}, 8'h01);
         chk_val({6'h00, timer_in, vref_in}, 8'h03);
         ext_level <= (c == 1) ? 8'h20 : 8'h01;
         repeat (4) @(posedge clock);
         chk_val({6'h00, ss_in, timer_in}, 8'h00);
      end
      wr(dir_a, 8'hEF, 4'h1);
      wr(lat_a, 8'h10, 4'h1);
      periph_own <= 8'h02;
      periph_out <= 8'h02;
      periph_oe <= 8'h02;
      repeat (4) @(posedge clock);
      chk_val({7'h00, timer_in}, 8'h01);
      chk_val(pad_oe, 8'h12);
      chk_val(pad_out, 8'h12);
   endtask : sc_periph
   task automatic sc_refuse();
      wr(4'h5, 8'h00, 4'h1);
      chk_resp(resp, gpio_port_pkg::resp_slverr);
      rd(dir_a);
      chk_val(got, 8'hEF);
      rd(4'h2);
      chk_resp(resp, gpio_port_pkg::resp_slverr);
      chk_val(got, 8'h00);
   endtask : sc_refuse
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      chk_val(pad_oe, 8'h00);
      chk_val({2'b00, an_en}, 8'h3F);
      rd(dir_a);
      chk_val(got, gpio_port_pkg::direction_reset);
      rd(ans_a);
      chk_val(got, 8'h3F);
      sc_output();
      sc_analog();
      sc_rmw();
      sc_periph();
      sc_refuse();
      stop_test();
   end
endmodule : port_a_gpio_tb
